/* File: src/adc_conv_ctl.sv */
/*
  conversion start, end-of-conversion status, parallel and serial result
  delivery of a 14-bit sampling converter.
  assumes host pins and master clock are asynchronous to core_clk_in, and
  the front end presents the held sample on sample_in.
*/
// Functional notes
// - mode one starts on start-pulse rising edge
// - mode one status low only when done
// - read strobe falling edge releases status
// - power-up status high, interrupt pending reset clear
// - word format gives 14 bits, no serial
// - byte format first read clears status
// - serial clock gated or continuous by format
// - mode two starts on chip-select, byte low
// - mode two holds on chip-select falling edge
// - mode two status low while converting
// - word reads wait on busy, then complete
// - lower byte first, upper byte plain read
// - serial behaviour same in both modes
// - conversion lasts 19 or 20 clock edges
// - byte select picks low or zero-padded high
// - sixteen-bit frame, two zeros, msb first
// - format select picks word, gated or continuous
`include "adc_ctl_params.svh"

module adc_conv_ctl (
  // clock and reset
  input  wire logic                    core_clk_in,
  input  wire logic                    rstn_in,
  // host pins
  input  wire logic                    convert_start_n_in,
  input  wire logic                    cs_n_in,
  input  wire logic                    rd_n_in,
  input  wire logic                    upper_byte_select_in,
  input  wire adc_ctl_pkg::format_t    format_sel_in,
  // master clock and front end
  input  wire logic                    master_clk_in,
  input  wire logic [`RESULT_W-1:0]    sample_in,
  output logic                         hold_out,
  // status and parallel data
  output logic                         busy_int_n_out,
  output logic [`RESULT_W-1:0]         data_out,
  output logic                         data_oe_n_out,
  // open-drain serial lines
  output adc_ctl_pkg::serial_oe_t      serial_oe_out
);

  // --------------------------------------------------------------------
  // pin synchronisation
  // --------------------------------------------------------------------
  logic [4:0] lvl;
  logic [4:0] rise;
  logic [4:0] fall;

  pin_sync #(.WIDTH(5)) u_sync (
    .core_clk_in    (core_clk_in),
    .rstn_in        (rstn_in),
    .pin_in         ({master_clk_in, convert_start_n_in, cs_n_in,
                      rd_n_in, upper_byte_select_in}),
    .reset_level_in (5'h1f),
    .level_out      (lvl),
    .rise_out       (rise),
    .fall_out       (fall)
  );

  logic mclk_rise;
  logic mclk_fall;
  logic mclk_lvl;
  logic start_lvl;
  logic ubs_lvl;
  logic mode2;
  logic read_act;
  logic word_fmt;
  assign mclk_rise = rise[4];
  assign mclk_fall = fall[4];
  assign mclk_lvl  = lvl[4];
  assign start_lvl = lvl[3];
  assign ubs_lvl   = lvl[0];
  // start input tied low selects the second mode
  assign mode2     = ~start_lvl;
  assign read_act  = ~lvl[2] & ~lvl[1];
  assign word_fmt  = (format_sel_in == adc_ctl_pkg::FMT_WORD);

  // --------------------------------------------------------------------
  // conversion sequencing
  // --------------------------------------------------------------------
  adc_ctl_pkg::conv_state_t state;
  adc_ctl_pkg::conv_state_t next_state;
  logic [4:0]            edge_cnt;
  logic [4:0]            next_edge_cnt;
  logic [2:0]            win_cnt;
  logic [2:0]            next_win_cnt;
  logic                  first_pend;
  logic                  next_first_pend;
  logic [`RESULT_W-1:0]  sample_q;
  logic [`RESULT_W-1:0]  next_sample_q;
  logic [`RESULT_W-1:0]  result;
  logic [`RESULT_W-1:0]  next_result;
  logic                  int_pend;
  logic                  next_int_pend;
  logic                  read_q;
  logic                  start_req;
  logic                  done;
  logic                  read_fall;

  // a second start while converting is ignored, not restarted
  // the start pulse pulls the synced level low, so mode2 reads high
  // while it lasts; a rising start edge only exists in mode one
  assign start_req = (state == adc_ctl_pkg::ST_IDLE) &&
                     (rise[3] ||
                      (mode2 && fall[2] && ~ubs_lvl));
  assign read_fall = read_act & ~read_q;

  always_comb
  begin
    next_state      = state;
    next_edge_cnt   = edge_cnt;
    next_win_cnt    = win_cnt;
    next_first_pend = first_pend;
    next_sample_q   = sample_q;
    next_result     = result;
    done            = 1'b0;
    if (start_req)
    begin
      next_state      = adc_ctl_pkg::ST_CONV;
      next_edge_cnt   = 5'h00;
      next_win_cnt    = 3'h0;
      next_first_pend = 1'b1;
      next_sample_q   = sample_in;
    end
    else if (state == adc_ctl_pkg::ST_CONV)
    begin
      if (win_cnt != 3'h7)
        next_win_cnt = win_cnt + 3'h1;
      if (mclk_rise)
      begin
        next_first_pend = 1'b0;
        // an edge too close to the start is not counted
        if (!(first_pend && (win_cnt < 3'(`START_WIN_CYC))))
        begin
          next_edge_cnt = edge_cnt + 5'h01;
          if (next_edge_cnt == `CONV_EDGES)
          begin
            done        = 1'b1;
            next_state  = adc_ctl_pkg::ST_IDLE;
            next_result = sample_q;
          end
        end
      end
    end
    // set wins over a clear in the same cycle
    next_int_pend = int_pend;
    if (read_fall && !mode2)
      next_int_pend = 1'b0;
    if (done && !mode2)
      next_int_pend = 1'b1;
  end

  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      state      <= adc_ctl_pkg::ST_IDLE;
      edge_cnt   <= 5'h00;
      win_cnt    <= 3'h0;
      first_pend <= 1'b0;
      sample_q   <= `RESULT_RST;
      result     <= `RESULT_RST;
      int_pend   <= `PWRUP_INT_RST;
      read_q     <= 1'b0;
    end
    else
    begin
      state      <= next_state;
      edge_cnt   <= next_edge_cnt;
      win_cnt    <= next_win_cnt;
      first_pend <= next_first_pend;
      sample_q   <= next_sample_q;
      result     <= next_result;
      int_pend   <= next_int_pend;
      read_q     <= read_act;
    end
  end

  logic conv;
  assign conv     = (state == adc_ctl_pkg::ST_CONV);
  assign hold_out = conv;
  assign busy_int_n_out = mode2 ? ~conv : ~int_pend;

  // --------------------------------------------------------------------
  // parallel read data
  // --------------------------------------------------------------------
  logic [`RESULT_W-1:0] next_data;

  always_comb
  begin
    if (word_fmt)
      next_data = result;
    else if (ubs_lvl)
      next_data = {8'h00,
                   result[`RESULT_W-1:`BYTE_HI_LSB]};
    else
      next_data = {6'h00, result[`BYTE_LO_MSB:0]};
  end

  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      data_out <= `RESULT_RST;
    else
      data_out <= next_data;
  end

  assign data_oe_n_out = ~read_act;

  // --------------------------------------------------------------------
  // serial frame
  // --------------------------------------------------------------------
  logic [15:0] shift;
  logic [15:0] next_shift;
  logic [4:0]  bit_cnt;
  logic [4:0]  next_bit_cnt;
  logic        frame_act;

  // identical in both modes: driven only by start and master clock
  // open through the low half of the last bit, so its fall is framed
  assign frame_act = conv && (bit_cnt <= `FRAME_BITS) && !word_fmt;

  always_comb
  begin
    next_shift   = shift;
    next_bit_cnt = bit_cnt;
    if (start_req)
    begin
      next_shift   = {2'b00, sample_in};
      next_bit_cnt = 5'h00;
    end
    else if (conv)
    begin
      if (mclk_fall && (bit_cnt < `FRAME_BITS))
        next_bit_cnt = bit_cnt + 5'h01;
      // the frame closes on the rise after its last bit was taken
      if (mclk_rise && (bit_cnt == `FRAME_BITS))
        next_bit_cnt = bit_cnt + 5'h01;
      // data moves on the rising edge after its bit was taken
      if (mclk_rise && (bit_cnt != 5'h00))
        next_shift = {shift[14:0], 1'b0};
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      shift   <= 16'h0000;
      bit_cnt <= 5'h00;
    end
    else
    begin
      shift   <= next_shift;
      bit_cnt <= next_bit_cnt;
    end
  end

  // gated clock lets several converters share one serial bus
  always_comb
  begin
    serial_oe_out.strobe_oe_n = ~frame_act;
    serial_oe_out.serial_data_out_oe_n  = ~(frame_act & ~shift[15]);
    if (format_sel_in == adc_ctl_pkg::FMT_BYTE_CONT)
      serial_oe_out.sclk_oe_n = mclk_lvl;
    else
      // no low half before the first counted fall: avoids a runt bit
      serial_oe_out.sclk_oe_n = ~(frame_act & ~mclk_lvl &
                                  (bit_cnt != 5'h00));
  end

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);

  sequence s_m1_start;
    rise[3] && !conv;
  endsequence
  sequence s_m2_start;
    mode2 && fall[2] && !ubs_lvl && !conv;
  endsequence

  property p_m1_start;
    s_m1_start |=> conv && hold_out;
  endproperty
  a_m1_start: assert property (p_m1_start)
    else $error("mode one start not taken");

  property p_m1_status;
    !mode2 && conv && !$past(int_pend) |-> busy_int_n_out;
  endproperty
  a_m1_status: assert property (p_m1_status)
    else $error("interrupt low during conversion");

  property p_int_clear;
    !mode2 && int_pend && read_fall && !done |=> busy_int_n_out;
  endproperty
  a_int_clear: assert property (p_int_clear)
    else $error("read did not release interrupt");

  property p_word_quiet;
    word_fmt |-> serial_oe_out.serial_data_out_oe_n && serial_oe_out.strobe_oe_n;
  endproperty
  a_word_quiet: assert property (p_word_quiet)
    else $error("serial active in word format");

  property p_m2_busy;
    s_m2_start |=> !busy_int_n_out [*2];
  endproperty
  a_m2_busy: assert property (p_m2_busy)
    else $error("busy not low after start");

  property p_m2_hold;
    s_m2_start |=> hold_out;
  endproperty
  a_m2_hold: assert property (p_m2_hold)
    else $error("no hold on chip-select edge");

  property p_edges;
    done |-> edge_cnt == 5'd18 && mclk_rise;
  endproperty
  a_edges: assert property (p_edges)
    else $error("conversion not 19 counted edges");

  property p_high_byte;
    !word_fmt && ubs_lvl ##1 !word_fmt
      |-> data_out[`RESULT_W-1:6] == 8'h00;
  endproperty
  a_high_byte: assert property (p_high_byte)
    else $error("upper byte not zero padded");

  property p_result_hold;
    !done |=> $stable(result);
  endproperty
  a_result_hold: assert property (p_result_hold)
    else $error("result changed without completion");

  property p_frame_start;
    start_req && !word_fmt |=> !serial_oe_out.strobe_oe_n
      && !serial_oe_out.serial_data_out_oe_n;
  endproperty
  a_frame_start: assert property (p_frame_start)
    else $error("frame not opened with leading zero");

endmodule // adc_conv_ctl

/* File: src/adc_ctl_params.svh */
/*
  timing counts, widths and reset values of the conversion control block.
  assumes a 250 mhz core clock and inclusion by bare name.
*/
`ifndef ADC_CTL_PARAMS_SVH
`define ADC_CTL_PARAMS_SVH

// ----------------------------------------------------------------------
// widths
// ----------------------------------------------------------------------
`define RESULT_W        14
`define FRAME_BITS      5'd16
`define BYTE_LO_MSB     7
`define BYTE_HI_LSB     8

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CONV_EDGES      5'd19
`define CORE_PERIOD_NS  4
`define START_WIN_NS    30
// longest time: rounded down, never below one cycle
`define START_WIN_CYC   (((`START_WIN_NS) / (`CORE_PERIOD_NS)) < 1 ? 1 : \
                         ((`START_WIN_NS) / (`CORE_PERIOD_NS)))

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RESULT_RST      14'h0000
`define PWRUP_INT_RST   1'b0

`endif

/* File: src/adc_ctl_pkg.sv */
/*
  types shared by the conversion control block.
  assumes adc_ctl_params.svh for all numbers.
*/
package adc_ctl_pkg;

  typedef enum logic [1:0] {
    FMT_WORD,
    FMT_BYTE_GATED,
    FMT_BYTE_CONT
  } format_t;

  typedef enum logic {
    ST_IDLE,
    ST_CONV
  } conv_state_t;

  // open-drain serial lines: low enable pulls the line low
  typedef struct packed {
    logic sclk_oe_n;
    logic serial_data_out_oe_n;
    logic strobe_oe_n;
  } serial_oe_t;

endpackage

/* File: src/pin_sync.sv */
/*
  three-stage synchroniser with agreement filter and edge pulses.
  assumes asynchronous pins; outputs are in the core clock domain.
*/
module pin_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             core_clk_in,
  input  wire logic             rstn_in,
  // pins and filtered views
  input  wire logic [WIDTH-1:0] pin_in,
  input  wire logic [WIDTH-1:0] reset_level_in,
  output logic      [WIDTH-1:0] level_out,
  output logic      [WIDTH-1:0] rise_out,
  output logic      [WIDTH-1:0] fall_out
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] level;
  logic [WIDTH-1:0] next_level;
  logic             primed;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      // a change counts only once stages two and three agree
      always_comb
      begin
        next_level[i] = (stage2[i] == stage3[i]) ? stage3[i] : level[i];
        // no edges until the stages hold the idle level
        rise_out[i]   = primed & next_level[i] & ~level[i];
        fall_out[i]   = primed & ~next_level[i] & level[i];
      end
    end
  endgenerate

  // reset level is a tie-off constant, caught after release
  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      stage1 <= '1;
      stage2 <= '1;
      stage3 <= '1;
      level  <= '1;
      primed <= 1'b0;
    end
    else if (!primed)
    begin
      stage1 <= reset_level_in;
      stage2 <= reset_level_in;
      stage3 <= reset_level_in;
      level  <= reset_level_in;
      primed <= 1'b1;
    end
    else
    begin
      stage1 <= pin_in;
      stage2 <= stage1;
      stage3 <= stage2;
      level  <= next_level;
    end
  end

  assign level_out = level;

endmodule // pin_sync

/* File: tb/adc_conv_ctl_bench.sv */
/*
  self-checking bench of the conversion control block.
  assumes the block's own assertions guard timing; drives host pins 1 ns
  after each core clock edge.
*/
`include "adc_ctl_params.svh"
`define CHK(what, exp, got) \
  begin \
    compares++; \
    if ((got) !== (exp)) \
    begin \
      n_fail++; \
      $display("Error %s expected %h seen %h", what, exp, got); \
    end \
  end

module adc_conv_ctl_bench;
  timeunit 1ns;
  timeprecision 100ps;

  logic                    core_clk;
  logic                    rstn;
  logic                    start_n;
  logic                    cs_n;
  logic                    rd_n;
  logic                    ubs;
  adc_ctl_pkg::format_t    fmt;
  logic                    mclk;
  logic [`RESULT_W-1:0]    sample;
  logic                    hold;
  logic                    busy_n;
  logic [`RESULT_W-1:0]    data;
  logic                    doe_n;
  adc_ctl_pkg::serial_oe_t soe;
  logic                    clr;
  logic                    sclk;
  logic [15:0]             word;
  logic [4:0]              bits;
  logic [13:0]             d;
  int                      n_fail;
  int                      compares;
  int                      cycles;

  adc_conv_ctl dut_u (
    .core_clk_in          (core_clk),
    .rstn_in              (rstn),
    .convert_start_n_in   (start_n),
    .cs_n_in              (cs_n),
    .rd_n_in              (rd_n),
    .upper_byte_select_in (ubs),
    .format_sel_in        (fmt),
    .master_clk_in        (mclk),
    .sample_in            (sample),
    .hold_out             (hold),
    .busy_int_n_out       (busy_n),
    .data_out             (data),
    .data_oe_n_out        (doe_n),
    .serial_oe_out        (soe)
  );

  serial_rx_model rx_u (
    .serial_oe_in   (soe),
    .clear_in       (clr),
    .master_clk_out (mclk),
    .sclk_out       (sclk),
    .word_out       (word),
    .bits_out       (bits)
  );

  // ----------------------------------------------------------------
  // clock, timeout and verdict
  // ----------------------------------------------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic results();
    if (n_fail == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // six conversions need about 5000 cycles
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_fail++;
      results();
    end
  end

  // ----------------------------------------------------------------
  // host access tasks
  // ----------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge core_clk) #1;
  endtask

  // bounded wait for status, hold or data enable to reach a level
  task automatic wait_sig(input int which, input logic lvl, output int n);
    logic s;
    n = 0;
    s = (which == 0) ? busy_n : (which == 1) ? hold : doe_n;
    while (s !== lvl && n < 2000)
    begin
      step(1);
      n++;
      s = (which == 0) ? busy_n : (which == 1) ? hold : doe_n;
    end
  endtask

  task automatic host_read(input logic upper, output logic [13:0] q);
    int n;
    ubs = upper;
    step(1);
    cs_n = 1'b0;
    rd_n = 1'b0;
    wait_sig(2, 1'b0, n);
    step(2);
    q = data;
    cs_n = 1'b1;
    rd_n = 1'b1;
    step(6);
  endtask

  task automatic arm(input logic [13:0] s, input adc_ctl_pkg::format_t f);
    fmt = f;
    sample = s;
    clr = 1'b1;
    step(1);
    clr = 1'b0;
  endtask

  // frame content, conversion length and clock release after the end
  task automatic finish_checks(input logic [13:0] s, input int n);
    int k;
    `CHK("conversion cycles", 1'b1, n >= 540 && n <= 620)
    `CHK("hold at end", 1'b0, hold)
    `CHK("frame bits", fmt == adc_ctl_pkg::FMT_WORD ? 5'd0 : 5'd16, bits)
    if (fmt != adc_ctl_pkg::FMT_WORD)
      `CHK("frame word", {2'b00, s}, word)
    k = 0;
    repeat (100)
    begin
      step(1);
      k += (sclk === 1'b0) ? 1 : 0;
    end
    `CHK("clock after frame", fmt == adc_ctl_pkg::FMT_BYTE_CONT, k > 0)
  endtask

  task automatic convert_m1(input logic [13:0] s,
                            input adc_ctl_pkg::format_t f);
    int n;
    arm(s, f);
    start_n = 1'b0;
    step(4);
    start_n = 1'b1;
    wait_sig(1, 1'b1, n);
    `CHK("hold after start", 1'b1, n < 12)
    `CHK("status while converting", 1'b1, busy_n)
    wait_sig(0, 1'b0, n);
    finish_checks(s, n);
    `CHK("status when done", 1'b0, busy_n)
  endtask

  // the host holds its read in a wait state until busy returns high
  task automatic convert_m2(input logic [13:0] s,
                            input adc_ctl_pkg::format_t f);
    int n;
    arm(s, f);
    ubs = 1'b0;
    step(1);
    cs_n = 1'b0;
    rd_n = 1'b0;
    wait_sig(0, 1'b0, n);
    `CHK("busy at start", 1'b1, n < 12)
    `CHK("hold on select", 1'b1, hold)
    wait_sig(0, 1'b1, n);
    step(3);
    `CHK("waited read", f == adc_ctl_pkg::FMT_WORD ? s : {6'h00, s[7:0]}, data)
    cs_n = 1'b1;
    rd_n = 1'b1;
    finish_checks(s, n + 3);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    rstn = 1'b0;
    start_n = 1'b1;
    cs_n = 1'b1;
    rd_n = 1'b1;
    ubs = 1'b0;
    fmt = adc_ctl_pkg::FMT_WORD;
    sample = 14'h0000;
    clr = 1'b0;
    step(4);
    rstn = 1'b1;
    step(8);
    host_read(1'b0, d);
    `CHK("idle status", 1'b1, busy_n)
    convert_m1(14'h2a5c, adc_ctl_pkg::FMT_WORD);
    host_read(1'b0, d);
    `CHK("word read", 14'h2a5c, d)
    `CHK("status after read", 1'b1, busy_n)
    host_read(1'b1, d);
    `CHK("repeat read", 14'h2a5c, d)
    convert_m1(14'h1387, adc_ctl_pkg::FMT_BYTE_GATED);
    host_read(1'b1, d);
    `CHK("upper byte first", 14'h0013, d)
    `CHK("status after first", 1'b1, busy_n)
    host_read(1'b0, d);
    `CHK("lower byte", 14'h0087, d)
    convert_m1(14'h3ff1, adc_ctl_pkg::FMT_BYTE_CONT);
    host_read(1'b1, d);
    `CHK("upper zero pad", 14'h003f, d)
    start_n = 1'b0;
    step(8);
    convert_m2(14'h0c3a, adc_ctl_pkg::FMT_WORD);
    convert_m2(14'h15a6, adc_ctl_pkg::FMT_BYTE_GATED);
    host_read(1'b1, d);
    `CHK("plain upper read", 14'h0015, d)
    `CHK("no restart", 1'b0, hold)
    convert_m2(14'h2e01, adc_ctl_pkg::FMT_BYTE_CONT);
    results();
  end
endmodule // adc_conv_ctl_bench

/* File: tb/serial_rx_model.sv */
/*
  serial receiver and free-running master clock beside the converter.
  assumes open-drain serial lines with pull-ups; clear_in empties the
  receiver before each conversion.
*/
module serial_rx_model (
  // serial lines and control
  input  wire adc_ctl_pkg::serial_oe_t serial_oe_in,
  input  wire logic                    clear_in,
  // master clock and received frame
  output logic                         master_clk_out,
  output logic                         sclk_out,
  output logic [15:0]                  word_out,
  output logic [4:0]                   bits_out
);
  timeunit 1ns;
  timeprecision 100ps;

  logic serial_data_out;
  logic strobe_n;

  // pull-ups: a released line reads high, never the last value
  assign sclk_out = serial_oe_in.sclk_oe_n;
  assign serial_data_out    = serial_oe_in.serial_data_out_oe_n;
  // strobe seen late: one falling with the clock is a setup miss
  assign #1 strobe_n = serial_oe_in.strobe_oe_n;

  // master clock runs free, unrelated in phase to the core clock
  initial
  begin
    master_clk_out = 1'b0;
    forever #62.5 master_clk_out = ~master_clk_out;
  end

  // bits are taken on the falling serial clock while framed
  always @(negedge sclk_out or posedge clear_in)
  begin
    if (clear_in)
    begin
      word_out <= 16'h0000;
      bits_out <= 5'h00;
    end
    else if (strobe_n == 1'b0)
    begin
      word_out <= {word_out[14:0], serial_data_out};
      bits_out <= bits_out + 5'h01;
    end
  end
endmodule // serial_rx_model
